// [gci_pkg.sv]
//==================================================
// Shared constants for the global configuration block
//==================================================
package gci_pkg;
	// Data path widths
	localparam int FP_W = 16; // Free pool counter width
	localparam int LEN_W = 16; // Frame byte count width
	localparam int DATA_W = 32; // Packet data word width
	localparam int BYTE_W = 8; // One byte lane
	localparam int LANES = DATA_W / BYTE_W; // Byte lanes per word

	// Reset values of the configuration bits (masks set, rest clear)
	localparam logic RST_MBOX_MASK = 1'h1;
	localparam logic RST_BRIDGE_MASK = 1'h1;
	localparam logic RST_WARN_MASK = 1'h1;
	localparam logic RST_FAIL_MASK = 1'h1;
	localparam logic RST_SHORT_SEL = 1'h0;
	localparam logic RST_MON_SEL = 1'h0;
	localparam logic RST_BYTE_ORDER = 1'h0;
	localparam logic [FP_W-1:0] RST_THRESHOLD = 16'hffff; // Top so the first count is a new minimum

	// Short frame limits in bytes, frame is short below these
	localparam logic [LEN_W-1:0] SHORT_STD_CRC16 = 16'h0004;
	localparam logic [LEN_W-1:0] SHORT_STD_CRC32 = 16'h0006;
	localparam logic [LEN_W-1:0] SHORT_ALT_CRC16 = 16'h0002;
	localparam logic [LEN_W-1:0] SHORT_ALT_CRC32 = 16'h0004;

	// Monitor mode encodings
	localparam logic MON_CAPTURE_MIN = 1'h0;
	localparam logic MON_THRESH_IRQ = 1'h1;

	// Byte order encodings
	localparam logic ORDER_LITTLE = 1'h0;
	localparam logic ORDER_BIG = 1'h1;
endpackage : gci_pkg

// [gci_swap.sv]
`timescale 1ns/1ps
//==================================================
// Registered byte lane swapper for packet data sections
//==================================================
module gci_swap (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic valid_i,
	input wire logic swap_i,
	input wire logic [gci_pkg::DATA_W-1:0] data_i,
	output logic valid_o,
	output logic [gci_pkg::DATA_W-1:0] data_o
);
	logic [gci_pkg::DATA_W-1:0] swapped; // Lane-reversed copy of the input

	// One generate loop mirrors the lanes, no muxing per lane by hand
	genvar g;
	generate
		for (g = 0; g < gci_pkg::LANES; g++) begin : g_lane
			assign swapped[g*gci_pkg::BYTE_W +: gci_pkg::BYTE_W] =
				data_i[(gci_pkg::LANES-1-g)*gci_pkg::BYTE_W +: gci_pkg::BYTE_W];
		end
	endgenerate

	// Output data register, held when no word arrives
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			data_o <= '0;
		end else if (valid_i) begin
			data_o <= swap_i ? swapped : data_i;
		end
	end

	// Valid follows the input by one cycle
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			valid_o <= 1'h0;
		end else begin
			valid_o <= valid_i;
		end
	end

	// Big endian word comes out with lanes reversed
	swap_big_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		valid_i && swap_i |=> valid_o && data_o == {$past(data_i[7:0]), $past(data_i[15:8]),
			$past(data_i[23:16]), $past(data_i[31:24])})
		else $error("big endian word not swapped");

	// Unswapped word passes untouched
	swap_none_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		valid_i && !swap_i |=> data_o == $past(data_i))
		else $error("word altered without swap");
endmodule : gci_swap

// [gci_top.sv]
`timescale 1ns/1ps
//==================================================
// Global configuration, vector masks, monitor and byte order
//==================================================
module gci_top (
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Configuration load, bits sampled when cfg_load_i is high
	input wire logic cfg_load_i,
	input wire logic mailbox_vector_mask_i,
	input wire logic bridge_vector_mask_i,
	input wire logic rxbuf_warning_vector_mask_i,
	input wire logic rxbuf_fail_vector_mask_i,
	input wire logic short_frame_select_i,
	input wire logic rxbuf_monitor_select_i,
	input wire logic data_byte_order_i,
	// Vector requests from the sources, one-cycle pulses
	input wire logic mbox_req_i,
	input wire logic bridge_err_req_i,
	input wire logic rxbuf_warn_req_i,
	input wire logic rxbuf_aq_warn_req_i,
	input wire logic rxbuf_fail_req_i,
	// Receive buffer monitor
	input wire logic [gci_pkg::FP_W-1:0] free_pool_cnt_i,
	input wire logic thr_wr_i,
	input wire logic [gci_pkg::FP_W-1:0] thr_wdata_i,
	// Frame end report from any channel
	input wire logic frame_end_i,
	input wire logic frame_crc32_i,
	input wire logic [gci_pkg::LEN_W-1:0] frame_len_i,
	// Memory transfer word
	input wire logic xfer_valid_i,
	input wire logic xfer_is_data_i,
	input wire logic [gci_pkg::DATA_W-1:0] xfer_data_i,
	// Outputs
	output logic mbox_vec_o,
	output logic bridge_err_vec_o,
	output logic rxbuf_warn_vec_o,
	output logic rxbuf_aq_warn_vec_o,
	output logic rxbuf_fail_vec_o,
	output logic rxbuf_below_irq_o,
	output logic [gci_pkg::FP_W-1:0] rxbuf_threshold_reg_o,
	output logic short_frame_o,
	output logic xfer_valid_o,
	output logic [gci_pkg::DATA_W-1:0] xfer_data_o,
	output logic [6:0] cfg_readback_o
);
	//==================================================
	// Configuration register
	//==================================================
	logic mbox_mask; // Mailbox vector mask
	logic bridge_mask; // Bridge error vector mask
	logic warn_mask; // Buffer warning vector mask
	logic fail_mask; // Buffer fail vector mask
	logic short_sel; // Short frame limit select
	logic mon_sel; // Monitor mode select
	logic byte_order; // Packet data byte order

	// Settings latch on load; events already in flight used the old copy
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mbox_mask <= gci_pkg::RST_MBOX_MASK;
			bridge_mask <= gci_pkg::RST_BRIDGE_MASK;
			warn_mask <= gci_pkg::RST_WARN_MASK;
			fail_mask <= gci_pkg::RST_FAIL_MASK;
			short_sel <= gci_pkg::RST_SHORT_SEL;
			mon_sel <= gci_pkg::RST_MON_SEL;
			byte_order <= gci_pkg::RST_BYTE_ORDER;
		end else if (cfg_load_i) begin
			mbox_mask <= mailbox_vector_mask_i;
			bridge_mask <= bridge_vector_mask_i;
			warn_mask <= rxbuf_warning_vector_mask_i;
			fail_mask <= rxbuf_fail_vector_mask_i;
			short_sel <= short_frame_select_i;
			mon_sel <= rxbuf_monitor_select_i;
			byte_order <= data_byte_order_i;
		end
	end

	// Readback of the live settings, bit 6 down to bit 0
	assign cfg_readback_o = {mbox_mask, bridge_mask, warn_mask, fail_mask, short_sel, mon_sel, byte_order};

	//==================================================
	// Vector masking
	//==================================================
	logic warn_block; // Warning mask counts only in threshold mode
	assign warn_block = warn_mask && (mon_sel == gci_pkg::MON_THRESH_IRQ);

	// Registered vector pulses gated by the masks
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mbox_vec_o <= 1'h0;
			bridge_err_vec_o <= 1'h0;
			rxbuf_warn_vec_o <= 1'h0;
			rxbuf_aq_warn_vec_o <= 1'h0;
			rxbuf_fail_vec_o <= 1'h0;
		end else begin
			mbox_vec_o <= mbox_req_i && !mbox_mask;
			bridge_err_vec_o <= bridge_err_req_i && !bridge_mask;
			rxbuf_warn_vec_o <= rxbuf_warn_req_i && !warn_block;
			rxbuf_aq_warn_vec_o <= rxbuf_aq_warn_req_i && !warn_block;
			rxbuf_fail_vec_o <= rxbuf_fail_req_i && !fail_mask;
		end
	end

	mbox_mask_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		mbox_req_i |=> mbox_vec_o == !$past(mbox_mask))
		else $error("mailbox vector disagrees with mask");

	bridge_mask_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		bridge_err_req_i |=> bridge_err_vec_o == !$past(bridge_mask))
		else $error("bridge vector disagrees with mask");

	warn_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		rxbuf_aq_warn_req_i && warn_mask && mon_sel |=> !rxbuf_aq_warn_vec_o)
		else $error("queue warning passed while masked");

	warn_ignore_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		rxbuf_warn_req_i && !mon_sel |=> rxbuf_warn_vec_o)
		else $error("warning lost in capture mode");

	fail_mask_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		rxbuf_fail_req_i |=> rxbuf_fail_vec_o == !$past(fail_mask))
		else $error("fail vector disagrees with mask");

	//==================================================
	// Receive buffer monitor
	//==================================================
	logic cnt_below; // Count under the stored threshold now
	logic was_below; // Count was under it last cycle
	assign cnt_below = free_pool_cnt_i < rxbuf_threshold_reg_o;

	// Threshold register; software write beats the minimum tracker
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rxbuf_threshold_reg_o <= gci_pkg::RST_THRESHOLD;
		end else if (thr_wr_i) begin
			rxbuf_threshold_reg_o <= thr_wdata_i;
		end else if (mon_sel == gci_pkg::MON_CAPTURE_MIN && cnt_below) begin
			rxbuf_threshold_reg_o <= free_pool_cnt_i;
		end
	end

	// Edge of falling under threshold, so a long dip gives one pulse
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			was_below <= 1'h0;
			rxbuf_below_irq_o <= 1'h0;
		end else begin
			was_below <= cnt_below;
			rxbuf_below_irq_o <= (mon_sel == gci_pkg::MON_THRESH_IRQ) && cnt_below && !was_below;
		end
	end

	min_track_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		!mon_sel && !thr_wr_i && cnt_below |=> rxbuf_threshold_reg_o == $past(free_pool_cnt_i))
		else $error("minimum count not recorded");

	below_irq_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		mon_sel && cnt_below && !was_below |=> rxbuf_below_irq_o ##1 !rxbuf_below_irq_o)
		else $error("threshold interrupt not a single pulse");

	//==================================================
	// Short frame classifier
	//==================================================
	logic [gci_pkg::LEN_W-1:0] short_limit; // Limit for this frame

	// One limit shared by every channel's frame end
	always_comb begin
		if (short_sel) begin
			short_limit = frame_crc32_i ? gci_pkg::SHORT_ALT_CRC32 : gci_pkg::SHORT_ALT_CRC16;
		end else begin
			short_limit = frame_crc32_i ? gci_pkg::SHORT_STD_CRC32 : gci_pkg::SHORT_STD_CRC16;
		end
	end

	// Verdict pulse one cycle after the frame end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			short_frame_o <= 1'h0;
		end else begin
			short_frame_o <= frame_end_i && (frame_len_i < short_limit);
		end
	end

	short_std_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		frame_end_i && !short_sel && frame_crc32_i |=> short_frame_o == ($past(frame_len_i) < gci_pkg::SHORT_STD_CRC32))
		else $error("standard CRC32 short verdict wrong");

	short_alt_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		frame_end_i && short_sel && !frame_crc32_i |=> short_frame_o == ($past(frame_len_i) < gci_pkg::SHORT_ALT_CRC16))
		else $error("alternate CRC16 short verdict wrong");

	//==================================================
	// Byte order on packet data only
	//==================================================
	gci_swap u_swap (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.valid_i(xfer_valid_i),
		.swap_i(xfer_is_data_i && byte_order == gci_pkg::ORDER_BIG),
		.data_i(xfer_data_i),
		.valid_o(xfer_valid_o),
		.data_o(xfer_data_o)
	);

	no_swap_meta_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
		xfer_valid_i && !xfer_is_data_i |=> xfer_data_o == $past(xfer_data_i))
		else $error("non-data word was swapped");
endmodule : gci_top

// [gci_tb.sv]
`timescale 1ns/1ps
//==================================================
// Self-checking bench for the global configuration block
//==================================================
module testbench;
	logic core_clk_i = 1'h0; // Bench clock, 10 MHz
	logic srst_i = 1'h1; // Held for two cycles at start
	logic cfg_load_i = 1'h0, mbox_m = 1'h0, br_m = 1'h0, warn_m = 1'h0, fail_m = 1'h0;
	logic sfs = 1'h0, mon = 1'h0, ord = 1'h0; // Config bits offered at load
	logic [4:0] req = 5'h00; // {mbox,bridge,warn,aq_warn,fail}
	logic [15:0] cnt = 16'h00ff, thr_wdata = 16'h0000; // Free pool and threshold write data
	logic thr_wr = 1'h0, fend = 1'h0, crc32 = 1'h0, xv = 1'h0, xd = 1'h0;
	logic [15:0] flen = 16'h0000; // Frame byte count
	logic [31:0] xdata = 32'h00000000; // Transfer word
	logic mbox_o, br_o, warn_o, aq_o, fail_o, irq_o, short_o, xv_o;
	logic [15:0] thr_o;
	logic [31:0] xd_o;
	logic [6:0] rb_o;
	int error_cnt = 0, cmp_count = 0, seed = 91;
	// Model state, plain integers and bits
	logic [6:0] m_cfg;
	logic [15:0] m_thr;
	logic [31:0] e_xd;
	logic m_pbelow, below;
	logic [4:0] e_vec;
	logic e_irq, e_short, e_xv;
	int lim;
	// Self initialization wait after any reset, 250 us at 100 ns per cycle
	localparam int INIT_CYC = 2500;
	int quiet = 0; // Cycles left in the hands-off window after reset

	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end

	gci_top i_gci_top (.core_clk_i(core_clk_i), .srst_i(srst_i), .cfg_load_i(cfg_load_i),
		.mailbox_vector_mask_i(mbox_m), .bridge_vector_mask_i(br_m), .rxbuf_warning_vector_mask_i(warn_m),
		.rxbuf_fail_vector_mask_i(fail_m), .short_frame_select_i(sfs), .rxbuf_monitor_select_i(mon),
		.data_byte_order_i(ord), .mbox_req_i(req[4]), .bridge_err_req_i(req[3]), .rxbuf_warn_req_i(req[2]),
		.rxbuf_aq_warn_req_i(req[1]), .rxbuf_fail_req_i(req[0]), .free_pool_cnt_i(cnt), .thr_wr_i(thr_wr),
		.thr_wdata_i(thr_wdata), .frame_end_i(fend), .frame_crc32_i(crc32), .frame_len_i(flen),
		.xfer_valid_i(xv), .xfer_is_data_i(xd), .xfer_data_i(xdata), .mbox_vec_o(mbox_o),
		.bridge_err_vec_o(br_o), .rxbuf_warn_vec_o(warn_o), .rxbuf_aq_warn_vec_o(aq_o),
		.rxbuf_fail_vec_o(fail_o), .rxbuf_below_irq_o(irq_o), .rxbuf_threshold_reg_o(thr_o),
		.short_frame_o(short_o), .xfer_valid_o(xv_o), .xfer_data_o(xd_o), .cfg_readback_o(rb_o));

	// Single compare point, case equality so an unknown matches only an unknown
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Advance the model by the edge just passed, using the inputs still held
	task automatic model_step();
		if (srst_i) begin
			m_cfg = 7'h78; // Masks set, other bits clear
			m_thr = 16'hffff;
			e_vec = 5'h00;
			{e_irq, e_short, e_xv, m_pbelow} = 4'h0;
			e_xd = 32'h00000000;
		end else begin
			e_vec[4] = req[4] & ~m_cfg[6];
			e_vec[3] = req[3] & ~m_cfg[5];
			e_vec[2] = req[2] & ~(m_cfg[4] & m_cfg[1]);
			e_vec[1] = req[1] & ~(m_cfg[4] & m_cfg[1]);
			e_vec[0] = req[0] & ~m_cfg[3];
			lim = m_cfg[2] ? (crc32 ? 4 : 2) : (crc32 ? 6 : 4);
			e_short = fend && (int'(flen) < lim);
			e_xv = xv;
			// Swap only packet data in big endian mode
			if (xv)
				e_xd = (xd && m_cfg[0]) ? {xdata[7:0], xdata[15:8], xdata[23:16], xdata[31:24]} : xdata;
			below = cnt < m_thr;
			e_irq = m_cfg[1] && below && !m_pbelow;
			m_pbelow = below;
			// Software write wins over the captured minimum
			if (thr_wr)
				m_thr = thr_wdata;
			else if (!m_cfg[1] && below)
				m_thr = cnt;
			if (cfg_load_i)
				m_cfg = {mbox_m, br_m, warn_m, fail_m, sfs, mon, ord};
		end
	endtask : model_step

	// Compare every result, then drive fresh random stimulus
	task automatic run(input int cycles, input int rst_at);
		for (int i = 0; i < cycles; i++) begin
			@(negedge core_clk_i);
			model_step();
			check("vectors", {27'h0, mbox_o, br_o, warn_o, aq_o, fail_o}, {27'h0, e_vec});
			check("below_irq", {31'h0, irq_o}, {31'h0, e_irq});
			check("threshold", {16'h0, thr_o}, {16'h0, m_thr});
			check("short", {31'h0, short_o}, {31'h0, e_short});
			check("xfer_valid", {31'h0, xv_o}, {31'h0, e_xv});
			check("xfer_data", xd_o, e_xd);
			check("readback", {25'h0, rb_o}, {25'h0, m_cfg});
			srst_i = (i == rst_at);
			// Software leaves the device alone while it self-initializes after reset
			if (srst_i)
				quiet = INIT_CYC;
			else if (quiet > 0)
				quiet--;
			cfg_load_i = (($random(seed) & 7) == 0) && (quiet == 0);
			{mbox_m, br_m, warn_m, fail_m, sfs, mon, ord} = 7'($random(seed));
			req = 5'($random(seed));
			cnt = 16'h0080 + 16'($random(seed) & 16'h007f);
			thr_wr = (($random(seed) & 15) == 0) && (quiet == 0);
			thr_wdata = 16'h0080 + 16'($random(seed) & 16'h007f);
			{fend, crc32, xv, xd} = 4'($random(seed));
			flen = 16'($random(seed) & 16'h0007);
			xdata = 32'($random(seed));
		end
	endtask : run

	// Verdict and end of run
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// Watchdog, well beyond the planned 8002 cycles
	initial begin
		#(10000 * 100);
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (2) @(negedge core_clk_i);
		srst_i = 1'h0;
		m_cfg = 7'h78;
		m_thr = 16'hffff;
		m_pbelow = 1'h0;
		e_xd = 32'h00000000; // Data register clears under reset
		quiet = INIT_CYC;
		run(4000, -1);
		$display("random test one done");
		// Second reset in mid-run, then more traffic
		run(4000, 700);
		$display("random test two done");
		wrap_up();
	end
endmodule : testbench
